/* File: rtl/dhp_pkg.sv */
// Functional notes
// - Count inverted phase-2 clock with a three-bit counter through states zero to seven.
// - Decode counter states zero, two and four into three spike-free phase ticks.
// - Bit clock is inverted state-four tick when writing, else inverted read clock.
// - One of eight port strobes, picked by address bits 2..0, only when enabled.
// - Base match needs A3 low, A5-A7 high; jumper chooses A4 high or low.
// - Input qualifier needs input strobe, input status, phase-2, and no DMA hold.
// - All port strobes are suppressed while a DMA hold is acknowledged.
// - Phase-2 qualification of input strobes can be switched off by configuration.
// - Output qualifier needs write strobe low, output status high, no DMA hold.
// - Either qualifier fires the decoded strobe, regardless of cycle direction.
// - All eight data-out lines are copied onto the internal data bus.
// - Drive command access with data bit 0 low gives one active-low step pulse.
// - End of drive command strobe stores data bits 1..7 into command register.
// - Command register outputs and step go to the drive active low.
// - Low address byte loads from port five, high byte from port six.
// - Address counter increments once for every byte moved during DMA.
// - Bus-transfer enable drives the address counter onto the bus address lines.
// - Low address byte strobe also clears latched DMA progress status bits.
package dhp_pkg;
	localparam int unsigned DHP_PHASE_W = 3;
	localparam logic [2:0] DHP_PHASE_TICK0 = 3'h0;
	localparam logic [2:0] DHP_PHASE_TICK2 = 3'h2;
	localparam logic [2:0] DHP_PHASE_TICK4 = 3'h4;
	localparam logic [2:0] DHP_PHASE_RST = 3'h0;
	localparam int unsigned DHP_PORT_SEL_W = 3;
	localparam int unsigned DHP_NUM_PORTS = 8;
	localparam int unsigned DHP_ADDR_A3 = 3;
	localparam int unsigned DHP_ADDR_A4 = 4;
	localparam int unsigned DHP_ADDR_A5 = 5;
	localparam int unsigned DHP_ADDR_A6 = 6;
	localparam int unsigned DHP_ADDR_A7 = 7;
	localparam logic [7:0] DHP_REG_ADDR_LOW = 8'hf5;
	localparam logic [7:0] DHP_REG_ADDR_HIGH = 8'hf6;
	localparam logic [7:0] DHP_REG_DRIVE_CMD = 8'hf7;
	localparam int unsigned DHP_STEP_BIT = 0;
	localparam int unsigned DHP_CMD_W = 7;
	localparam logic [6:0] DHP_CMD_RST = 7'h00;
	localparam logic [15:0] DHP_ADDR_RST = 16'h0000;
	localparam logic [7:0] DHP_DATA_RST = 8'h00;
	localparam int unsigned DHP_CLK_PERIOD_PS = 4000;
endpackage

/* File: rtl/dhp_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module dhp_sync2 #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// First stage feeds only the second stage
	always_comb begin
		meta_d = i_async;
		sync_d = meta_q;
		if (i_srst) begin
			meta_d = '0;
			sync_d = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign o_sync = sync_q;
endmodule // dhp_sync2
`default_nettype wire

/* File: rtl/dhp_host_port.sv */
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port
	import dhp_pkg::*;
#(
	parameter int unsigned ADDR_W = 16
) (
	input wire logic i_clk,
	input wire logic i_srst,
	// Bus pins, asynchronous
	input wire logic i_phi2,
	input wire logic i_pdbin,
	input wire logic i_sinp,
	input wire logic i_pwr_n,
	input wire logic i_sout,
	input wire logic i_phldar,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_data_out,
	// Formatter and jumpers, asynchronous
	input wire logic i_read_recovered_clk,
	input wire logic i_alt_base_select,
	input wire logic i_phi2_qual_en,
	// Controller logic on this clock
	input wire logic i_writing,
	input wire logic i_byte_moved,
	input wire logic i_address_drive_enable,
	// Outputs
	output logic o_phase_tick0,
	output logic o_phase_tick2,
	output logic o_phase_tick4,
	output logic o_bit_clk,
	output logic [DHP_NUM_PORTS-1:0] o_port_strobe,
	output logic [7:0] o_internal_data,
	output logic o_step_n,
	output logic [DHP_CMD_W-1:0] o_drive_cmd_n,
	output logic o_status_clear,
	output logic [ADDR_W-1:0] o_addr_bus,
	output logic o_addr_oe_n
);
	localparam int unsigned SYNC_W = 7 + 8 + 8 + 2;

	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_out;
	logic phi2_s;
	logic pdbin_s;
	logic sinp_s;
	logic pwr_n_s;
	logic sout_s;
	logic phldar_s;
	logic rclk_s;
	logic [7:0] addr_s;
	logic [7:0] data_s;
	logic alt_base_s;
	logic phi2_qual_en_s;

	assign sync_in = {i_phi2, i_pdbin, i_sinp, i_pwr_n, i_sout, i_phldar, i_read_recovered_clk,
		i_addr, i_data_out, i_alt_base_select, i_phi2_qual_en};

	dhp_sync2 #(
		.WIDTH(SYNC_W)
	) u_sync (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_async(sync_in),
		.o_sync(sync_out)
	);

	assign {phi2_s, pdbin_s, sinp_s, pwr_n_s, sout_s, phldar_s, rclk_s,
		addr_s, data_s, alt_base_s, phi2_qual_en_s} = sync_out;

	function automatic logic base_match(input logic [7:0] a, input logic alt);
		logic a4_ok;
		a4_ok = alt ? ~a[DHP_ADDR_A4] : a[DHP_ADDR_A4];
		base_match = ~a[DHP_ADDR_A3] & a4_ok & a[DHP_ADDR_A5] & a[DHP_ADDR_A6] & a[DHP_ADDR_A7];
	endfunction

	function automatic logic [2:0] port_sel(input logic [7:0] port);
		port_sel = port[DHP_PORT_SEL_W-1:0];
	endfunction

	// Phase counter and ticks
	logic phi2_prev_q;
	logic phi2_prev_d;
	logic [DHP_PHASE_W-1:0] phase_q;
	logic [DHP_PHASE_W-1:0] phase_d;
	logic tick0_q;
	logic tick0_d;
	logic tick2_q;
	logic tick2_d;
	logic tick4_q;
	logic tick4_d;
	logic bit_clk_q;
	logic bit_clk_d;
	logic phi2_fall;

	assign phi2_fall = phi2_prev_q & ~phi2_s;

	always_comb begin
		phi2_prev_d = phi2_s;
		phase_d = phase_q;
		if (phi2_fall) begin
			phase_d = phase_q + 3'h1;
		end
		// Registered decode cannot glitch when several counter bits change at once
		tick0_d = (phase_q == DHP_PHASE_TICK0);
		tick2_d = (phase_q == DHP_PHASE_TICK2);
		tick4_d = (phase_q == DHP_PHASE_TICK4);
		bit_clk_d = i_writing ? ~tick4_q : ~rclk_s;
		if (i_srst) begin
			phi2_prev_d = 1'b0;
			phase_d = DHP_PHASE_RST;
			tick0_d = 1'b0;
			tick2_d = 1'b0;
			tick4_d = 1'b0;
			bit_clk_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		phi2_prev_q <= phi2_prev_d;
		phase_q <= phase_d;
		tick0_q <= tick0_d;
		tick2_q <= tick2_d;
		tick4_q <= tick4_d;
		bit_clk_q <= bit_clk_d;
	end

	assign o_phase_tick0 = tick0_q;
	assign o_phase_tick2 = tick2_q;
	assign o_phase_tick4 = tick4_q;
	assign o_bit_clk = bit_clk_q;

	// Port decode
	logic in_qual;
	logic out_qual;
	logic strobe_en;
	logic [DHP_NUM_PORTS-1:0] strobe_d;
	logic [DHP_NUM_PORTS-1:0] strobe_q;
	logic [7:0] data_q;
	logic [7:0] data_d;

	// Some hosts see phase-2 too late on input cycles, so qualification is optional
	assign in_qual = pdbin_s & sinp_s & (phi2_s | ~phi2_qual_en_s) & ~phldar_s;
	assign out_qual = ~pwr_n_s & sout_s & ~phldar_s;
	// Direction is not checked; a wrong-direction access still strobes the port
	assign strobe_en = (in_qual | out_qual) & base_match(addr_s, alt_base_s) & ~phldar_s;

	generate
		for (genvar p = 0; p < DHP_NUM_PORTS; p++) begin : g_port
			always_comb begin
				strobe_d[p] = strobe_en & (port_sel(addr_s) == 3'(p));
				if (i_srst) begin
					strobe_d[p] = 1'b0;
				end
			end
		end
	endgenerate

	always_comb begin
		data_d = data_s;
		if (i_srst) begin
			data_d = DHP_DATA_RST;
		end
	end

	always_ff @(posedge i_clk) begin
		strobe_q <= strobe_d;
		data_q <= data_d;
	end

	assign o_port_strobe = strobe_q;
	assign o_internal_data = data_q;

	// Strobe ends are the load points, data is held from the last strobe cycle
	logic [DHP_NUM_PORTS-1:0] strobe_end;
	assign strobe_end = strobe_q & ~strobe_d;

	// Drive command
	logic step_n_q;
	logic step_n_d;
	logic [DHP_CMD_W-1:0] cmd_n_q;
	logic [DHP_CMD_W-1:0] cmd_n_d;

	always_comb begin
		step_n_d = ~(strobe_d[port_sel(DHP_REG_DRIVE_CMD)] & ~data_s[DHP_STEP_BIT]);
		cmd_n_d = cmd_n_q;
		if (strobe_end[port_sel(DHP_REG_DRIVE_CMD)]) begin
			cmd_n_d = ~data_q[7:1];
		end
		if (i_srst) begin
			step_n_d = 1'b1;
			cmd_n_d = ~DHP_CMD_RST;
		end
	end

	always_ff @(posedge i_clk) begin
		step_n_q <= step_n_d;
		cmd_n_q <= cmd_n_d;
	end

	assign o_step_n = step_n_q;
	assign o_drive_cmd_n = cmd_n_q;

	// Address counter
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_d;
	logic [ADDR_W-1:0] addr_bus_q;
	logic [ADDR_W-1:0] addr_bus_d;
	logic addr_oe_n_q;
	logic addr_oe_n_d;
	logic status_clr_q;
	logic status_clr_d;
	logic load_lo;
	logic load_hi;

	assign load_lo = strobe_end[port_sel(DHP_REG_ADDR_LOW)];
	assign load_hi = strobe_end[port_sel(DHP_REG_ADDR_HIGH)];

	always_comb begin
		addr_d = addr_q;
		if (i_byte_moved) begin
			addr_d = addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
		end
		// A load overrides a count in the same cycle; halves load independently
		if (load_lo) begin
			addr_d[7:0] = data_q;
		end
		if (load_hi) begin
			addr_d[ADDR_W-1:8] = data_q[ADDR_W-9:0];
		end
		status_clr_d = load_lo;
		addr_bus_d = i_address_drive_enable ? addr_q : addr_bus_q;
		addr_oe_n_d = ~i_address_drive_enable;
		if (i_srst) begin
			addr_d = DHP_ADDR_RST[ADDR_W-1:0];
			status_clr_d = 1'b0;
			addr_bus_d = DHP_ADDR_RST[ADDR_W-1:0];
			addr_oe_n_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		addr_q <= addr_d;
		status_clr_q <= status_clr_d;
		addr_bus_q <= addr_bus_d;
		addr_oe_n_q <= addr_oe_n_d;
	end

	assign o_status_clear = status_clr_q;
	assign o_addr_bus = addr_bus_q;
	assign o_addr_oe_n = addr_oe_n_q;
endmodule // dhp_host_port
`default_nettype wire

/* File: sim/dhp_host_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port_monitor (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_phi2,
	input wire logic i_pdbin,
	input wire logic i_sinp,
	input wire logic i_pwr_n,
	input wire logic i_sout,
	input wire logic i_phldar,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_data_out,
	input wire logic i_alt_base_select,
	input wire logic i_phi2_qual_en,
	input wire logic i_address_drive_enable,
	input wire logic [7:0] o_port_strobe,
	input wire logic [7:0] o_internal_data,
	input wire logic o_step_n,
	input wire logic [6:0] o_drive_cmd_n,
	input wire logic o_status_clear,
	input wire logic o_addr_oe_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// Pins reach the strobe three edges late: two sync flops and a register
	wire hit = i_addr[7:5] == 3'h7 && !i_addr[3] && i_addr[4] != i_alt_base_select;
	property p_hold; i_phldar [*4] |-> o_port_strobe == 8'h00; endproperty
	a_hold: assert property (p_hold) else $error("strobe in hold");
	property p_dec; |o_port_strobe |-> $past(hit, 3) && o_port_strobe == 8'h01 << $past(i_addr[2:0], 3); endproperty
	a_dec: assert property (p_dec) else $error("bad decode");
	property p_out; $past(!i_pwr_n && i_sout && !i_phldar && hit, 3) |-> |o_port_strobe; endproperty
	a_out: assert property (p_out) else $error("no write strobe");
	property p_in; $past(i_pdbin && i_sinp && !i_phi2 && i_phi2_qual_en && i_pwr_n, 3) |-> o_port_strobe == 8'h00; endproperty
	a_in: assert property (p_in) else $error("read strobe without phase");
	property p_step; !o_step_n |-> o_port_strobe[7] && !$past(i_data_out[0], 3); endproperty
	a_step: assert property (p_step) else $error("bad step");
	property p_cmd; $fell(o_port_strobe[7]) |-> o_drive_cmd_n == ~$past(o_internal_data[7:1]); endproperty
	a_cmd: assert property (p_cmd) else $error("bad command");
	property p_clr; $fell(o_port_strobe[5]) |-> ##[0:1] o_status_clear ##1 !o_status_clear; endproperty
	a_clr: assert property (p_clr) else $error("no status clear");
	property p_oe; 1 |=> o_addr_oe_n == !$past(i_address_drive_enable); endproperty
	a_oe: assert property (p_oe) else $error("bad address enable");
	c_cmd: cover property ($fell(o_port_strobe[7]));
	c_clr: cover property (o_status_clear);
	c_step: cover property (!o_step_n);
endmodule // dhp_host_port_monitor
bind dhp_host_port dhp_host_port_monitor i_mon (.*);
`default_nettype wire

/* File: sim/dhp_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dhp_bus_model (
	input wire logic i_clk,
	output logic o_phi2 = 1'b0,
	output logic o_pdbin = 1'b0,
	output logic o_sinp = 1'b0,
	output logic o_pwr_n = 1'b1,
	output logic o_sout = 1'b0,
	output logic [7:0] o_addr = 8'h00,
	output logic [7:0] o_data = 8'h00
);
	// Bus clock runs free with a 24 ns period, every edge on an i_clk falling edge
	always #12 o_phi2 = ~o_phi2;
	// Direction is chosen by software, the block strobes either way
	task io(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		o_addr = a;
		o_data = d;
		o_sout = w;
		o_pwr_n = !w;
		o_sinp = !w;
		o_pdbin = !w;
		repeat (6) @(posedge i_clk);
		#1;
		o_sout = 1'b0;
		o_pwr_n = 1'b1;
		o_sinp = 1'b0;
		o_pdbin = 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
		// Released lines show the inverse, never a stale copy
		o_addr = ~a;
		o_data = ~d;
		repeat (3) @(posedge i_clk);
		#1;
	endtask
endmodule // dhp_bus_model
`default_nettype wire

/* File: sim/dhp_host_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port_test;
	import dhp_pkg::*;
	logic i_clk = 0, i_srst = 1, hlda = 0, rclk = 0, alt = 0, qen = 0, wrt = 0, bm = 0, ade = 0, sv_q = 0;
	wire logic phi2, pdbin, sinp, pwr_n, sout;
	wire logic [7:0] addr, dout;
	logic t0, t2, t4, bclk, stp_n, sclr, oe_n;
	logic [7:0] stb, idat, d, e;
	logic [6:0] cmd_n;
	logic [15:0] abus;
	logic [31:0] rs = 32'h00000056;
	logic [7:0] qs[$];
	int errors = 0, n_tests = 0, nst = 0, nclk = 0, c;
	dhp_bus_model i_dhp_bus_model (.i_clk(i_clk), .o_phi2(phi2), .o_pdbin(pdbin), .o_sinp(sinp),
		.o_pwr_n(pwr_n), .o_sout(sout), .o_addr(addr), .o_data(dout));
	dhp_host_port #(.ADDR_W(16)) i_dhp_host_port (.i_clk(i_clk), .i_srst(i_srst), .i_phi2(phi2),
		.i_pdbin(pdbin), .i_sinp(sinp), .i_pwr_n(pwr_n), .i_sout(sout), .i_phldar(hlda), .i_addr(addr),
		.i_data_out(dout), .i_read_recovered_clk(rclk), .i_alt_base_select(alt), .i_phi2_qual_en(qen),
		.i_writing(wrt), .i_byte_moved(bm), .i_address_drive_enable(ade), .o_phase_tick0(t0),
		.o_phase_tick2(t2), .o_phase_tick4(t4), .o_bit_clk(bclk), .o_port_strobe(stb),
		.o_internal_data(idat), .o_step_n(stp_n), .o_drive_cmd_n(cmd_n), .o_status_clear(sclr),
		.o_addr_bus(abus), .o_addr_oe_n(oe_n));
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task chk(input string n, input logic [15:0] x, input logic [15:0] s);
		n_tests++;
		if (s !== x) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [7:0] dd, input logic [7:0] x);
		if (x !== 8'h00) qs.push_back(x);
		i_dhp_bus_model.io(w, a, dd);
	endtask
	task tally_and_finish();
		$display("errors %0d checks %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always #2 i_clk = ~i_clk;
	always @(posedge i_clk) nclk++;
	always @(posedge i_clk) if (stp_n === 1'b0) nst++;
	// Each new strobe takes the oldest note; an unexpected one meets zero
	always @(posedge i_clk) begin
		sv_q <= |stb;
		if ((|stb) === 1'b1 && !sv_q) chk("strobe", {8'h00, qs.size() ? qs.pop_front() : 8'h00}, {8'h00, stb});
	end
	initial begin
		#20000;
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge i_clk);
		#1;
		i_srst = 0;
		for (int p = 0; p < 8; p++) acc(1, 8'hf0 | 8'(p), 8'h01, 8'h01 << p);
		acc(0, 8'hf0, 8'h00, 8'h01);
		acc(1, 8'hf8, 8'h00, 8'h00);
		alt = 1;
		acc(1, 8'he3, 8'h00, 8'h08);
		acc(1, 8'hf3, 8'h00, 8'h00);
		alt = 0;
		hlda = 1;
		qen = 1;
		acc(1, 8'hf7, 8'h00, 8'h00);
		acc(0, 8'hf1, 8'h00, 8'h00);
		hlda = 0;
		// Start just after phase-2 falls so the qualified read gives a single strobe
		@(negedge phi2);
		acc(0, 8'hf0, 8'h00, 8'h01);
		qen = 0;
		for (int k = 0; k < 2; k++) begin
			d = 8'(rnd());
			d[0] = k[0];
			c = nst;
			acc(1, 8'hf7, d, 8'h80);
			chk("step", k ? 16'h0000 : 16'h0006, 16'(nst - c));
			chk("cmd", {9'h000, ~d[7:1]}, {9'h000, cmd_n});
		end
		ade = 1;
		d = 8'(rnd());
		e = 8'(rnd());
		acc(1, 8'hf5, d, 8'h20);
		acc(1, 8'hf6, e, 8'h40);
		chk("addr", {e, d}, abus);
		chk("data", {8'h00, ~e}, {8'h00, idat});
		acc(1, 8'hf5, 8'hff, 8'h20);
		acc(1, 8'hf6, 8'hff, 8'h40);
		bm = 1;
		repeat (3) @(posedge i_clk);
		#1;
		bm = 0;
		repeat (2) @(posedge i_clk);
		#1;
		chk("addr", 16'h0002, abus);
		chk("oe", 16'h0000, {15'h0000, oe_n});
		ade = 0;
		repeat (2) @(posedge i_clk);
		#1;
		chk("oe", 16'h0001, {15'h0000, oe_n});
		chk("data", {8'h00, dout}, {8'h00, idat});
		@(posedge t0);
		c = nclk;
		@(posedge t2);
		chk("tick2", 16'h000c, 16'(nclk - c));
		@(posedge t0);
		chk("tick0", 16'h0030, 16'(nclk - c));
		#1;
		wrt = 1;
		@(posedge t4);
		repeat (2) @(posedge i_clk);
		#1;
		chk("bclk", 16'h0000, {15'h0000, bclk});
		wrt = 0;
		for (int k = 0; k < 2; k++) begin
			rclk = k[0];
			repeat (5) @(posedge i_clk);
			#1;
			chk("bclk", {15'h0000, !rclk}, {15'h0000, bclk});
		end
		chk("left", 16'h0000, 16'(qs.size()));
		tally_and_finish();
	end
endmodule // dhp_host_port_test
`default_nettype wire
